/* design/eeprom_pkg.sv */
// shared constants for the two-wire serial memory slave
package eeprom_pkg;
  // array shape
  localparam int          MEM_DEPTH          = 256;
  localparam int          PAGE_BYTES         = 8;
  localparam logic [3:0]  DEV_TYPE_CODE      = 4'ha;
  localparam logic [3:0]  BITS_PER_WORD      = 4'h8;
  // programming interval
  localparam int          CLK_PERIOD_NS      = 40;
  localparam int          PROGRAMMING_CYCLE_TIME_NS = 5000000;
  localparam int          PROG_CYCLES_DEF    = PROGRAMMING_CYCLE_TIME_NS / CLK_PERIOD_NS;
  // register map (byte addresses)
  localparam logic [3:0]  STATUS_OFS         = 4'h0;
  localparam logic [3:0]  PEEK_ADDR_OFS      = 4'h4;
  localparam logic [3:0]  PEEK_DATA_OFS      = 4'h8;
  localparam logic [7:0]  PEEK_ADDR_RST      = 8'h00;
  localparam logic [7:0]  ADDR_CNT_RST       = 8'h00;
  // bus responses
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;
  // link states
  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_RDATA, ST_PROG} link_state_e;
endpackage

/* design/pin_sync.sv */
// two-flop synchroniser for the asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] pins_sync
);
  logic [WIDTH-1:0] meta_reg;  // first stage, read only by the second

  // second stage resets high: an idle two-wire bus floats high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg  <= '1;
      pins_sync <= '1;
    end
    else
    begin
      meta_reg  <= pins_in;
      pins_sync <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* design/serial_eeprom_bus_slave.sv */
// two-wire serial memory slave with write control and a register peek port
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_bus_slave
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF  // programming interval in clocks
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // two-wire link
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // strap and protect pins
  input  wire logic        wp_i,
  input  wire logic [2:0]  chip_select_straps,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // synchronised pins
  logic [5:0]  pin_s;          // {straps, wp, sda, scl}
  logic        scl_s;
  logic        sda_s;
  logic        wp_s;
  logic [2:0]  straps_s;
  logic        scl_d_reg;      // previous sampled clock
  logic        sda_d_reg;      // previous sampled data
  // link datapath
  link_state_e state_reg;
  logic [3:0]  bit_cnt_reg;    // bits moved in the current word
  logic        ack_ph_reg;     // inside the ninth clock
  logic        mack_reg;       // master acknowledged the read byte
  logic [7:0]  shift_reg;      // receive shifter
  logic [7:0]  tx_reg;         // transmit shifter
  logic [7:0]  addr_cnt_reg;   // internal word address counter
  // array and page buffer
  logic [7:0]  mem_reg [MEM_DEPTH];
  logic [7:0]  page_buf_reg [PAGE_BYTES];
  logic [7:0]  page_mask_reg;  // which columns hold new data
  logic [31:0] prog_cnt_reg;
  // register side
  logic [7:0]  peek_addr_reg;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  // events
  logic        scl_rise;
  logic        scl_fall;
  logic        ev_start;
  logic        ev_stop;
  logic        word_in_done;   // eighth received bit has just finished
  logic        dev_match;
  logic        write_go;
  logic        prog_done;
  logic [7:0]  rd_byte;

  assign scl_s    = pin_s[0];
  assign sda_s    = pin_s[1];
  assign wp_s     = pin_s[2];
  assign straps_s = pin_s[5:3];

  pin_sync #(
    .WIDTH (6)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pins_in   ({chip_select_straps, wp_i, sda_i, scl_i}),
    .pins_sync (pin_s)
  );

  // edge history of the synchronised link lines
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // data moves only with clock low, so a data edge with clock high is framing
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign ev_start  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign ev_stop   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign word_in_done = scl_fall & ~ack_ph_reg & (bit_cnt_reg == BITS_PER_WORD);
  // type code and straps must match; busy never answers a poll
  assign dev_match = (shift_reg[7:4] == DEV_TYPE_CODE)
                   & (shift_reg[3:1] == straps_s);
  // protect pin sampled at the stop blocks the whole program cycle
  assign write_go  = ev_stop & (state_reg == ST_WDATA)
                   & (page_mask_reg != 8'h00) & ~wp_s;
  assign prog_done = (state_reg == ST_PROG)
                   & (prog_cnt_reg == 32'(PROG_CYCLES - 1));
  assign rd_byte   = mem_reg[addr_cnt_reg];

  // link state machine, shifters and address counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      ack_ph_reg   <= 1'b0;
      mack_reg     <= 1'b0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      addr_cnt_reg <= ADDR_CNT_RST;
      sda_oe       <= 1'b0;
    end
    else if (state_reg == ST_PROG)
    begin
      // pins are ignored, so address polls go unanswered
      sda_oe <= 1'b0;
      if (prog_done)
        state_reg <= ST_IDLE;
    end
    else if (ev_start)
    begin
      // a new command drops any unprogrammed write
      state_reg   <= ST_DEV;
      bit_cnt_reg <= 4'h0;
      ack_ph_reg  <= 1'b0;
      sda_oe      <= 1'b0;
    end
    else if (ev_stop)
    begin
      sda_oe    <= 1'b0;
      state_reg <= write_go ? ST_PROG : ST_IDLE;
    end
    else
    begin
      case (state_reg)
        ST_DEV, ST_WADDR, ST_WDATA:
        begin
          if (scl_rise && !ack_ph_reg && bit_cnt_reg != BITS_PER_WORD)
          begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (word_in_done)
          begin
            // decide the ninth clock; the line is only ever pulled low
            ack_ph_reg <= 1'b1;
            if (state_reg == ST_DEV)
            begin
              if (dev_match)
                sda_oe <= 1'b1;
              else
                state_reg <= ST_IDLE;
            end
            else
            begin
              sda_oe <= 1'b1;
              if (state_reg == ST_WADDR)
                addr_cnt_reg <= shift_reg;
              else
                addr_cnt_reg <= {addr_cnt_reg[7:3], addr_cnt_reg[2:0] + 3'h1};
            end
          end
          else if (scl_fall && ack_ph_reg)
          begin
            // end of the ninth clock: release, or drive the first read bit, and move on
            ack_ph_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_DEV && shift_reg[0])
            begin
              state_reg <= ST_RDATA;
              sda_oe    <= ~rd_byte[7];
              tx_reg    <= {rd_byte[6:0], 1'b0};
            end
            else
            begin
              sda_oe <= 1'b0;
              if (state_reg == ST_DEV)
                state_reg <= ST_WADDR;
              else
                state_reg <= ST_WDATA;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
          begin
            if (ack_ph_reg)
              mack_reg <= ~sda_s;
            else
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && !ack_ph_reg)
          begin
            if (bit_cnt_reg == BITS_PER_WORD)
            begin
              // byte sent: let the master answer, count wraps past the top
              sda_oe       <= 1'b0;
              ack_ph_reg   <= 1'b1;
              addr_cnt_reg <= addr_cnt_reg + 8'h01;
            end
            else
            begin
              sda_oe <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
          else if (scl_fall && ack_ph_reg)
          begin
            ack_ph_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (mack_reg)
            begin
              sda_oe <= ~rd_byte[7];
              tx_reg <= {rd_byte[6:0], 1'b0};
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        default:
          sda_oe <= 1'b0;
      endcase
    end
  end

  // the driven level is always low: open drain
  always_ff @(posedge aclk)
  begin
    sda_o <= 1'b0;
  end

  // page buffer gathers data until the stop commits it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      page_mask_reg <= 8'h00;
    else if (prog_done || (ev_start && state_reg != ST_PROG))
      page_mask_reg <= 8'h00;
    else if (ev_stop && state_reg != ST_PROG && !write_go)
      page_mask_reg <= 8'h00;
    else if (word_in_done && state_reg == ST_WDATA)
      page_mask_reg[addr_cnt_reg[2:0]] <= 1'b1;
  end

  // buffer contents need no reset; the mask says what is valid
  always_ff @(posedge aclk)
  begin
    if (word_in_done && state_reg == ST_WDATA && state_reg != ST_PROG)
      page_buf_reg[addr_cnt_reg[2:0]] <= shift_reg;
  end

  // self-timed programming interval
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prog_cnt_reg <= 32'h0;
    else if (state_reg != ST_PROG)
      prog_cnt_reg <= 32'h0;
    else
      prog_cnt_reg <= prog_cnt_reg + 32'h1;
  end

  // nonvolatile array: kept through reset, written only at the interval's end
  always_ff @(posedge aclk)
  begin
    if (prog_done)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (page_mask_reg[i])
          mem_reg[{addr_cnt_reg[7:3], 3'(i)}] <= page_buf_reg[i];
      end
    end
  end

  // register write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      peek_addr_reg <= PEEK_ADDR_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid)
      begin
        // both halves held: commit and answer
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == PEEK_ADDR_OFS)
        begin
          s_axi_bresp <= RESP_OKAY;
          if (w_strb_reg[0])
            peek_addr_reg <= w_data_reg[7:0];
        end
        else if (aw_addr_reg == STATUS_OFS || aw_addr_reg == PEEK_DATA_OFS)
          s_axi_bresp <= RESP_OKAY;  // read-only, write dropped
        else
          s_axi_bresp <= RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // register read channel: one outstanding read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr)
        STATUS_OFS:
          s_axi_rdata <= {16'h0, addr_cnt_reg, 5'h0, state_reg == ST_IDLE,
                          wp_s, state_reg == ST_PROG};
        PEEK_ADDR_OFS:
          s_axi_rdata <= {24'h0, peek_addr_reg};
        PEEK_DATA_OFS:
          s_axi_rdata <= {24'h0, mem_reg[peek_addr_reg]};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* sim/link_master.sv */
// two-wire bus master model, clocks the link at 320 ns
`timescale 1ns/1ns
`default_nettype none
module link_master (
  // system clock
  input  wire logic aclk,
  // resolved data line
  input  wire logic sda,
  // master pins, sdm high means released
  output logic      scl,
  output logic      sdm
);
  // idle high between frames
  initial
  begin
    scl = 1'b1;
    sdm = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // start from idle or from clock low
  task automatic start();
    sdm <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdm <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sdm <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdm <= 1'b1;
    tick(4);
  endtask
  // data moves two clocks after the fall, well inside the low phase
  task automatic bit_io(input logic b, output logic r);
    sdm <= b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    r = sda;
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // mack high asks for another byte
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, r);
  endtask
endmodule
`default_nettype wire

/* sim/serial_eeprom_bus_slave_asserts.sv */
// port checker for the serial memory slave
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_bus_slave_asserts
  import eeprom_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // two-wire link
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] rd_ofs_reg;  // offset of the read in flight
  // remember the offset, rdata alone does not say what it is
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      rd_ofs_reg <= s_axi_araddr;
  end
  // link side
  property p_pull_only; sda_oe |-> !sda_o; endproperty
  a_pull_only: assert property (p_pull_only) else $error("line driven high");
  property p_shift_low; $changed(sda_oe) |-> !scl_i || !$past(scl_i); endproperty
  a_shift_low: assert property (p_shift_low) else $error("drive moved, clock high");
  property p_start_quiet; scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe [*8]; endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
  property p_stop_quiet; scl_i && $past(scl_i) && $rose(sda_i) |-> !sda_oe [*8]; endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
  property p_reset_idle;
    $rose(aresetn) |-> !sda_oe && s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  // busy and standby never shown together
  property p_busy_excl;
    s_axi_rvalid && rd_ofs_reg == STATUS_OFS && s_axi_rdata[0] |-> !s_axi_rdata[2];
  endproperty
  a_busy_excl: assert property (p_busy_excl) else $error("busy in standby");
  // register bus timing as handed over
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write answer late");
  property p_r_time; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r_time: assert property (p_r_time) else $error("read answer late");
  c_start: cover property (scl_i && $fell(sda_i));
  c_ack: cover property ($rose(sda_oe));
  c_busy: cover property (s_axi_rvalid && rd_ofs_reg == STATUS_OFS && s_axi_rdata[0]);
endmodule
bind serial_eeprom_bus_slave serial_eeprom_bus_slave_asserts chk_i (
  .aclk(aclk), .aresetn(aresetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the serial memory slave
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import eeprom_pkg::*;
;
  localparam int PROG = 200;  // short programming interval
  logic        aclk = 1'b0;  // 25 MHz
  logic        aresetn = 1'b0;
  logic        wp, ack, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, scl, sdm;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [1:0]  bresp, rresp, rrsp, brsp;
  logic [15:0] stat;  // counter, then low status bits
  logic [7:0]  d;
  int          num_errors = 0;
  int          compares = 0;
  wire logic   sda;
  assign sda = sdm & ~sda_oe;  // pull-up, either side pulls low
  always #20 aclk = ~aclk;
  serial_eeprom_bus_slave #(.PROG_CYCLES(PROG)) uut (
    .aclk(aclk), .aresetn(aresetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .wp_i(wp), .chip_select_straps(3'h5), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  link_master lm (.aclk(aclk), .sda(sda), .scl(scl), .sdm(sdm));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // each channel held until its own ready
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        brsp = bresp;
        bready <= 1'b0;
      end
    end while (awvalid || wvalid || bready);
  endtask
  task automatic axi_rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rdat = rdata;
        rrsp = rresp;
        rready <= 1'b0;
      end
    end while (arvalid || rready);
  endtask
  task automatic status();
    axi_rd(STATUS_OFS);
    stat = {rdat[15:8], 5'h0, rdat[2:0]};
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] exp);
    axi_wr(PEEK_ADDR_OFS, {24'h0, a});
    chk(brsp, RESP_OKAY);
    axi_rd(PEEK_DATA_OFS);
    chk({24'h0, rdat[7:0]}, {24'h0, exp});
  endtask
  // write command with n data bytes counting up from base
  task automatic put(input logic [7:0] wa, input int n, input logic [7:0] base);
    lm.start();
    lm.wbyte(8'haa, ack);
    chk(ack, 1'b1);
    lm.wbyte(wa, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      lm.wbyte(base + 8'(i), ack);
      chk(ack, 1'b1);
    end
    lm.stop();
  endtask
  task automatic results();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // a hang counts as a failure
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    results();
  end
  initial
  begin
    {wp, awvalid, wvalid, bready, arvalid, rready} <= '0;
    {awaddr, araddr, wdata} <= '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    status();
    chk(stat, 16'h0004);
    axi_rd(4'hc);
    chk(rrsp, RESP_SLVERR);
    axi_wr(4'hc, 32'h0);
    chk(brsp, RESP_SLVERR);
    // foreign type code, then foreign straps
    for (int i = 0; i < 2; i++)
    begin
      lm.start();
      lm.wbyte(i ? 8'ha8 : 8'hba, ack);
      chk(ack, 1'b0);
      lm.stop();
    end
    put(8'h15, 1, 8'ha5);
    status();
    chk(stat[2:0], 3'b001);
    lm.start();
    lm.wbyte(8'haa, ack);
    chk(ack, 1'b0);
    lm.stop();
    repeat (PROG) @(posedge aclk);
    lm.start();
    lm.wbyte(8'haa, ack);
    chk(ack, 1'b1);
    lm.stop();
    status();
    chk(stat[2:0], 3'b100);
    peek(8'h15, 8'ha5);
    // protected write leaves the array alone
    wp <= 1'b1;
    put(8'h15, 1, 8'h3c);
    status();
    chk(stat[2:0], 3'b110);
    wp <= 1'b0;
    peek(8'h15, 8'ha5);
    // ten bytes from column 6 roll over the same page
    put(8'h16, 10, 8'h30);
    repeat (PROG + 20) @(posedge aclk);
    status();
    chk(stat, 16'h1004);
    for (int c = 0; c < 8; c++)
      peek(8'h10 + 8'(c), 8'h30 + 8'((c + 2) % 8) + (c >= 6 ? 8'h8 : 8'h0));
    // the peek address keeps the last value written
    axi_rd(PEEK_ADDR_OFS);
    chk(rdat, 32'h0000_0017);
    // dummy write then sequential read
    lm.start();
    lm.wbyte(8'haa, ack);
    lm.wbyte(8'h15, ack);
    lm.start();
    lm.wbyte(8'hab, ack);
    chk(ack, 1'b1);
    lm.rbyte(1'b1, d);
    chk(d, 8'h37);
    lm.rbyte(1'b0, d);
    chk(d, 8'h38);
    lm.stop();
    status();
    chk(stat, 16'h1704);
    // top byte written first, so the wrapping read drives known data
    put(8'hff, 1, 8'h5a);
    repeat (PROG + 20) @(posedge aclk);
    status();
    chk(stat, 16'hf804);
    lm.start();
    lm.wbyte(8'haa, ack);
    lm.wbyte(8'hff, ack);
    lm.start();
    lm.wbyte(8'hab, ack);
    lm.rbyte(1'b0, d);
    chk(d, 8'h5a);
    lm.stop();
    status();
    chk(stat, 16'h0004);
    results();
  end
endmodule
`default_nettype wire
